// >>> hdl/upp_user_pin_port.v
// Contract
// (R1) after reset every user pin is an input until software sets its direction bit.
// (R2) each pin has its own direction bit, 0 for input and 1 for output.
// (R3) pins 0 to 7 are read and written through the data register at 0x90 with direction at 0x91.
// (R4) pins 0 to 7 are multi-use while pin 8 is plain I/O with data bit 0 at 0xa0 and direction bit 0 at 0xa1.
// (R5) each of pins 0 to 7 has its own selector, and values 0 and 1 route it nowhere.
// (R6) selector 2 routes the pin to the timer 0 gate/clock and 3 to the timer 1 gate/clock.
// (R7) selectors 4 and 5 drive interrupt 0 and 1 from the pin uninverted, high active.
// (R8) selectors 6 and 7 drive interrupt 0 and 1 from the inverted pin, low active.
// (R9) pins routed to the same resource are combined by a logical OR.
// (R10) edge or level sensitivity of a routed interrupt is set by the interrupt type bits, not the selector.
// (R11) four selector registers each hold two pins: even pin in bits 2:0, odd pin in bits 6:4, bits 7 and 3 unused.
// (R12) an output pin drives its data bit and an input pin reads back its synchronised level.
`timescale 1ns/1ns
`default_nettype none
`include "upp_consts.vh"

module upp_user_pin_port #(
	parameter NPINS = 9,
	parameter NMUX = 8
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst_b,
	// special-function register port
	input wire [7:0] i_sfr_addr,
	input wire i_sfr_wr,
	input wire [7:0] i_sfr_wdata,
	output reg [7:0] o_sfr_rdata,
	// extended register port
	input wire [15:0] i_xreg_addr,
	input wire i_xreg_wr,
	input wire [7:0] i_xreg_wdata,
	output reg [7:0] o_xreg_rdata,
	// pins
	input wire [NPINS-1:0] i_pin,
	output reg [NPINS-1:0] o_pin,
	output reg [NPINS-1:0] o_pin_oe,
	// routed resources
	output reg o_timer_zero_gate_clock,
	output reg o_timer_one_gate_clock,
	output reg o_ext_int_zero,
	output reg o_ext_int_one
);

	reg [NPINS-1:0] pin_meta_ff;
	reg [NPINS-1:0] pin_sync_ff;
	reg [7:0] low_data_ff;
	reg [7:0] low_dir_ff;
	reg pin8_data_ff;
	reg pin8_dir_ff;
	reg [3*NMUX-1:0] sel_ff;
	wire [NMUX-1:0] hit_t0;
	wire [NMUX-1:0] hit_t1;
	wire [NMUX-1:0] hit_i0;
	wire [NMUX-1:0] hit_i1;
	wire [NPINS-1:0] pin_view;
	reg [7:0] nxt_sfr_rdata;
	reg [7:0] nxt_xreg_rdata;

	// select register index of an extended address, or 4 when unmapped
	function [2:0] sel_index;
		input [15:0] addr;
		reg [15:0] offset;
		begin
			offset = addr - `UPP_ADDR_SEL_BASE;
			if (addr >= `UPP_ADDR_SEL_PINS_0_1 && addr <= `UPP_ADDR_SEL_PINS_6_7) begin
				sel_index = offset[2:0];
			end else begin
				sel_index = 3'h4;
			end
		end
	endfunction

	// readback image of one select register, spare bits as zero
	function [7:0] sel_view;
		input [5:0] pair;
		begin
			sel_view = {1'h0, pair[5:3], 1'h0, pair[2:0]}; // R11
		end
	endfunction

	// interrupt request of one pin for its high-active and low-active codes
	function int_hit;
		input [2:0] sel;
		input [2:0] code_high;
		input [2:0] code_low;
		input lvl;
		begin
			int_hit = ((sel == code_high) & lvl) | ((sel == code_low) & ~lvl); // R7 R8
		end
	endfunction

	// pin inputs pass two flip-flops
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			pin_meta_ff <= {NPINS{1'b0}};
			pin_sync_ff <= {NPINS{1'b0}};
		end else begin
			pin_meta_ff <= i_pin;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// data and direction registers
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			low_data_ff <= `UPP_RST_DATA;
			low_dir_ff <= `UPP_RST_DIR; // R1
			pin8_data_ff <= 1'b0;
			pin8_dir_ff <= 1'b0; // R1
		end else if (i_sfr_wr) begin
			case (i_sfr_addr)
				`UPP_ADDR_LOW_DATA: begin
					low_data_ff <= i_sfr_wdata; // R3
				end
				`UPP_ADDR_LOW_DIR: begin
					low_dir_ff <= i_sfr_wdata; // R3
				end
				`UPP_ADDR_PIN8_DATA: begin
					pin8_data_ff <= i_sfr_wdata[0]; // R4
				end
				`UPP_ADDR_PIN8_DIR: begin
					pin8_dir_ff <= i_sfr_wdata[0]; // R4
				end
				default: begin
				end
			endcase
		end
	end

	// selector registers, two pins per register
	genvar g;
	generate
		for (g = 0; g < NMUX / 2; g = g + 1) begin : g_selreg
			always @(posedge i_clk) begin
				if (!i_rst_b) begin
					sel_ff[6*g +: 6] <= {`UPP_RST_SEL, `UPP_RST_SEL};
				end else if (i_xreg_wr && sel_index(i_xreg_addr) == g) begin
					sel_ff[6*g +: 3] <= i_xreg_wdata[`UPP_SEL_EVEN_LSB +: `UPP_SEL_W]; // R11
					sel_ff[6*g+3 +: 3] <= i_xreg_wdata[`UPP_SEL_ODD_LSB +: `UPP_SEL_W]; // R11
				end
			end
		end
		// per-pin routing decode
		for (g = 0; g < NMUX; g = g + 1) begin : g_route
			wire [2:0] s = sel_ff[3*g +: 3];
			wire lvl = pin_sync_ff[g];
			assign hit_t0[g] = (s == `UPP_SEL_TIMER0) & lvl; // R5 R6
			assign hit_t1[g] = (s == `UPP_SEL_TIMER1) & lvl; // R6
			assign hit_i0[g] = int_hit(s, `UPP_SEL_INT0_HIGH, `UPP_SEL_INT0_LOW, lvl); // R7 R8
			assign hit_i1[g] = int_hit(s, `UPP_SEL_INT1_HIGH, `UPP_SEL_INT1_LOW, lvl); // R7 R8
		end
	endgenerate

	// readback: output pins show their data bit, inputs their level
	assign pin_view = ({pin8_dir_ff, low_dir_ff} & {pin8_data_ff, low_data_ff})
		| (~{pin8_dir_ff, low_dir_ff} & pin_sync_ff); // R12

	// special-function readback
	always @* begin
		case (i_sfr_addr)
			`UPP_ADDR_LOW_DATA: begin
				nxt_sfr_rdata = pin_view[7:0]; // R3
			end
			`UPP_ADDR_LOW_DIR: begin
				nxt_sfr_rdata = low_dir_ff;
			end
			`UPP_ADDR_PIN8_DATA: begin
				nxt_sfr_rdata = {7'h00, pin_view[8]}; // R4
			end
			`UPP_ADDR_PIN8_DIR: begin
				nxt_sfr_rdata = {7'h00, pin8_dir_ff};
			end
			default: begin
				nxt_sfr_rdata = 8'h00;
			end
		endcase
	end

	// selector readback
	always @* begin
		case (sel_index(i_xreg_addr))
			3'h0: begin
				nxt_xreg_rdata = sel_view(sel_ff[5:0]); // R11
			end
			3'h1: begin
				nxt_xreg_rdata = sel_view(sel_ff[11:6]); // R11
			end
			3'h2: begin
				nxt_xreg_rdata = sel_view(sel_ff[17:12]); // R11
			end
			3'h3: begin
				nxt_xreg_rdata = sel_view(sel_ff[23:18]); // R11
			end
			default: begin
				nxt_xreg_rdata = 8'h00;
			end
		endcase
	end

	// registered outputs
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_sfr_rdata <= 8'h00;
			o_xreg_rdata <= 8'h00;
			o_pin <= {NPINS{1'b0}};
			o_pin_oe <= {NPINS{1'b0}}; // R1
			o_timer_zero_gate_clock <= 1'b0;
			o_timer_one_gate_clock <= 1'b0;
			o_ext_int_zero <= 1'b0;
			o_ext_int_one <= 1'b0;
		end else begin
			o_sfr_rdata <= nxt_sfr_rdata;
			o_xreg_rdata <= nxt_xreg_rdata;
			o_pin <= {pin8_data_ff, low_data_ff}; // R12
			o_pin_oe <= {pin8_dir_ff, low_dir_ff}; // R2
			o_timer_zero_gate_clock <= |hit_t0; // R9
			o_timer_one_gate_clock <= |hit_t1; // R9
			// plain levels; the interrupt controller applies its type bits
			o_ext_int_zero <= |hit_i0; // R9 R10
			o_ext_int_one <= |hit_i1; // R9 R10
		end
	end

endmodule

`default_nettype wire

// >>> hdl/upp_consts.vh
`ifndef UPP_CONSTS_VH
`define UPP_CONSTS_VH

// special-function register addresses
`define UPP_ADDR_LOW_DATA 8'h90
`define UPP_ADDR_LOW_DIR 8'h91
`define UPP_ADDR_PIN8_DATA 8'ha0
`define UPP_ADDR_PIN8_DIR 8'ha1

// resource select registers in the extended register space
`define UPP_ADDR_SEL_BASE 16'hff90
`define UPP_ADDR_SEL_PINS_0_1 16'hff90
`define UPP_ADDR_SEL_PINS_2_3 16'hff91
`define UPP_ADDR_SEL_PINS_4_5 16'hff92
`define UPP_ADDR_SEL_PINS_6_7 16'hff93

// field positions inside a select register
`define UPP_SEL_EVEN_LSB 0
`define UPP_SEL_ODD_LSB 4
`define UPP_SEL_W 3

// reset values
`define UPP_RST_DATA 8'h00
`define UPP_RST_DIR 8'h00
`define UPP_RST_SEL 3'h0

// selector codes
`define UPP_SEL_NONE_A 3'h0
`define UPP_SEL_NONE_B 3'h1
`define UPP_SEL_TIMER0 3'h2
`define UPP_SEL_TIMER1 3'h3
`define UPP_SEL_INT0_HIGH 3'h4
`define UPP_SEL_INT1_HIGH 3'h5
`define UPP_SEL_INT0_LOW 3'h6
`define UPP_SEL_INT1_LOW 3'h7

`endif

// >>> verification/upp_board.sv
`timescale 1ns/1ns
`default_nettype none
module upp_board (
	input wire [8:0] i_drv,
	input wire [8:0] i_dout,
	input wire [8:0] i_oe,
	output wire [8:0] o_lvl
);
	// a driven pin shows the device level, else the board level
	assign o_lvl = (i_oe & i_dout) | (~i_oe & i_drv);
endmodule
`default_nettype wire

// >>> verification/upp_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module upp_port_monitor #(parameter NPINS = 9) (
	input wire i_clk, i_rst_b, i_sfr_wr, i_xreg_wr, o_ext_int_one,
	input wire [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_xreg_wdata, o_xreg_rdata,
	input wire [15:0] i_xreg_addr,
	input wire [NPINS-1:0] o_pin, o_pin_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	a_reset_to_input: assert property (disable iff (1'b0) !i_rst_b |=> o_pin_oe == 0 && !o_ext_int_one)
		else $error("pin driven after reset");
	a_dir_to_oe: assert property (i_sfr_wr && i_sfr_addr == 8'h91 |-> ##2 o_pin_oe[7:0] == $past(i_sfr_wdata, 2))
		else $error("direction write lost");
	a_data_to_pin: assert property (i_sfr_wr && i_sfr_addr == 8'h90 |-> ##2 o_pin[7:0] == $past(i_sfr_wdata, 2))
		else $error("data write lost");
	a_pin8_dir: assert property (i_sfr_wr && i_sfr_addr == 8'ha1 |-> ##2 o_pin_oe[8] == $past(i_sfr_wdata[0], 2))
		else $error("pin8 direction lost");
	a_pin8_upper: assert property ($past(i_sfr_addr) == 8'ha1 |-> o_sfr_rdata[7:1] == 7'h00)
		else $error("pin8 upper bits set");
	a_dir_holds: assert property ($past(i_rst_b) && !$past(i_sfr_wr, 2) |-> $stable(o_pin_oe))
		else $error("direction moved unasked");
	a_sel_read: assert property (i_xreg_wr && i_xreg_addr == 16'hff92 ##1 !i_xreg_wr && i_xreg_addr == 16'hff92
		|=> o_xreg_rdata == ($past(i_xreg_wdata, 2) & 8'h77)) else $error("selector readback wrong");
	a_spare_bits: assert property (o_xreg_rdata[7] == 1'b0 && o_xreg_rdata[3] == 1'b0)
		else $error("spare selector bits set");
endmodule
bind upp_user_pin_port upp_port_monitor #(.NPINS(NPINS)) u_mon(
	.i_clk(i_clk),
	.i_rst_b(i_rst_b),
	.i_sfr_wr(i_sfr_wr),
	.i_xreg_wr(i_xreg_wr),
	.o_ext_int_one(o_ext_int_one),
	.i_sfr_addr(i_sfr_addr),
	.i_sfr_wdata(i_sfr_wdata),
	.o_sfr_rdata(o_sfr_rdata),
	.i_xreg_wdata(i_xreg_wdata),
	.o_xreg_rdata(o_xreg_rdata),
	.i_xreg_addr(i_xreg_addr),
	.o_pin(o_pin),
	.o_pin_oe(o_pin_oe)
);
`default_nettype wire

// >>> verification/tb_upp_user_pin_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_upp_user_pin_port;
	reg i_clk = 0, i_rst_b = 0, i_sfr_wr = 0, i_xreg_wr = 0;
	reg [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, i_xreg_wdata = 0, d, r, sv;
	reg [23:0] msel = 0;
	reg [15:0] i_xreg_addr = 0;
	reg [8:0] drv = 0;
	wire [8:0] i_pin, o_pin, o_pin_oe;
	wire [7:0] o_sfr_rdata, o_xreg_rdata;
	wire o_timer_zero_gate_clock, o_timer_one_gate_clock, o_ext_int_zero, o_ext_int_one;
	wire [3:0] res_out = {o_timer_zero_gate_clock, o_timer_one_gate_clock, o_ext_int_zero, o_ext_int_one};
	integer seed = 27, error_cnt = 0, n_compared = 0, k;
	always #5 i_clk = ~i_clk;
	upp_board pm(.i_drv(drv), .i_dout(o_pin), .i_oe(o_pin_oe), .o_lvl(i_pin));
	upp_user_pin_port uut(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr),
		.i_sfr_wdata(i_sfr_wdata),
		.o_sfr_rdata(o_sfr_rdata),
		.i_xreg_addr(i_xreg_addr),
		.i_xreg_wr(i_xreg_wr),
		.i_xreg_wdata(i_xreg_wdata),
		.o_xreg_rdata(o_xreg_rdata),
		.i_pin(i_pin),
		.o_pin(o_pin),
		.o_pin_oe(o_pin_oe),
		.o_timer_zero_gate_clock(o_timer_zero_gate_clock),
		.o_timer_one_gate_clock(o_timer_one_gate_clock),
		.o_ext_int_zero(o_ext_int_zero),
		.o_ext_int_one(o_ext_int_one)
	);
	function [3:0] res(input [2:0] s, input p);
		res = {s == 2 && p, s == 3 && p, s == 4 && p || s == 6 && !p, s == 5 && p || s == 7 && !p};
	endfunction
	function [3:0] res_all(input [23:0] sv_all, input [7:0] lv);
		integer j;
		begin
			res_all = 4'h0;
			for (j = 0; j < 8; j = j + 1) res_all = res_all | res(sv_all[3*j +: 3], lv[j]);
		end
	endfunction
	task chk(input [8:0] g, input [8:0] e);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("BAD %0t %h %h", $time, g, e);
			end
		end
	endtask
	task acc(input x, input w, input [15:0] a, input [7:0] v);
		begin
			@(posedge i_clk);
			{i_sfr_addr, i_xreg_addr} <= {a[7:0], a};
			{i_sfr_wdata, i_xreg_wdata} <= {v, v};
			{i_sfr_wr, i_xreg_wr} <= {w & ~x, w & x};
			@(posedge i_clk);
			{i_sfr_wr, i_xreg_wr} <= 2'h0;
			repeat (4) @(posedge i_clk);
			#1;
		end
	endtask
	task end_of_test;
		begin
			if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1;
		#1 chk(o_pin_oe, 0);
		for (k = 0; k < 22; k = k + 1) begin
			{d, r} = 16'($random(seed));
			sv = 8'($random(seed));
			if (k < 2) d = {8{k[0]}};
			@(posedge i_clk);
			drv <= 9'($random(seed));
			acc(0, 1, 16'h91, d);
			acc(0, 1, 16'h90, r);
			chk(o_pin, {1'b0, r});
			chk(o_sfr_rdata, d & r | ~d & drv[7:0]);
			acc(1, 1, 16'hff90 + k[1:0], sv);
			msel[6*k[1:0] +: 6] = {sv[6:4], sv[2:0]};
			chk(o_xreg_rdata, sv & 8'h77);
			chk(res_out, res_all(msel, d & r | ~d & drv[7:0]));
		end
		acc(0, 1, 16'ha1, 8'hff);
		chk(o_sfr_rdata, 8'h01);
		acc(0, 1, 16'ha0, 8'hff);
		chk(o_sfr_rdata, 8'h01);
		chk(o_pin[8], 1'b1);
		acc(0, 1, 16'h91, 8'h00);
		chk(o_sfr_rdata, 8'h00);
		acc(1, 1, 16'hff90, 8'h05);
		acc(1, 1, 16'hff91, 8'h00);
		acc(1, 1, 16'hff93, 8'h00);
		chk(o_xreg_rdata, 8'h00);
		@(posedge i_clk);
		drv <= 9'h010;
		acc(1, 1, 16'hff92, 8'hff);
		chk(o_xreg_rdata, 8'h77);
		chk(o_ext_int_one, 1);
		@(posedge i_clk);
		drv <= 9'h031;
		acc(1, 0, 16'hff92, 8'h00);
		chk(o_ext_int_one, 1);
		end_of_test;
	end
endmodule
`default_nettype wire
